// [hdl/frs_sequencer.sv]
`timescale 1ns/1ps
`include "frs_params.svh"

// Notes on behaviour
// - setting zero: no restart, stay off
// - codes one to five give that many attempts
// - all ones retries without any limit
// - attempts used up: latch off until cleared
// - start-to-start spacing from delay field and unit
// - delay code n means 2**n units
// - code six gives six attempts then latch
// - command off or other fault stops retrying

module frs_sequencer (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire frs_pkg::frs_retry_t retry_setting,
  input  wire frs_pkg::frs_delay_t delay_code,
  input  wire logic                unit_tick,
  input  wire logic                output_cmd_on,
  input  wire logic                fault_shutdown,
  input  wire logic                other_fault_shutdown,
  input  wire logic                fault_clear,
  output wire logic                output_enable,
  output wire logic                retry_wait,
  output wire logic                latched_off,
  output wire logic                attempt_start,
  output wire frs_pkg::frs_retry_t attempts_left
);

  ////////////////////////////////////////////////////////////////////////////
  // state and decode

  frs_pkg::frs_state_e state_r;
  frs_pkg::frs_state_e state_nxt;
  frs_pkg::frs_retry_t attempts_left_r;
  frs_pkg::frs_retry_t attempts_left_nxt;
  logic                output_enable_r;
  logic                retry_wait_r;
  logic                latched_off_r;
  logic                attempt_start_r;

  wire logic continuous;
  wire logic retries_avail;
  wire logic in_idle;
  wire logic in_run;
  wire logic in_wait;
  wire logic fresh_on;
  wire logic reload_cnt;
  wire logic fault_to_wait;
  wire logic attempt_go;
  wire logic timer_start;
  wire logic timer_expired;

  assign in_idle = state_r == frs_pkg::frs_st_idle;
  assign in_run  = state_r == frs_pkg::frs_st_run;
  assign in_wait = state_r == frs_pkg::frs_st_wait;

  assign continuous    = frs_pkg::frs_is_continuous(retry_setting);
  // the count of zero leaves only the latch path open
  assign retries_avail = continuous || attempts_left_r != `FRS_RETRY_NONE;

  assign fresh_on   = in_idle && output_cmd_on;
  assign reload_cnt = fault_clear || fresh_on;

  assign fault_to_wait = in_run && fault_shutdown && !other_fault_shutdown &&
                         output_cmd_on && retries_avail;
  assign attempt_go    = in_wait && timer_expired && !other_fault_shutdown &&
                         output_cmd_on && retries_avail;

  // timer runs from each attempt start; a fault after it ran out rearms it
  assign timer_start = attempt_go || (fault_to_wait && timer_expired);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      frs_pkg::frs_st_idle: begin
        if (output_cmd_on) begin
          state_nxt = frs_pkg::frs_st_run;
        end
      end
      frs_pkg::frs_st_run: begin
        if (other_fault_shutdown) begin
          state_nxt = frs_pkg::frs_st_latch;
        end else if (!output_cmd_on) begin
          state_nxt = frs_pkg::frs_st_idle;
        end else if (fault_shutdown) begin
          state_nxt = retries_avail ? frs_pkg::frs_st_wait :
                                      frs_pkg::frs_st_latch;
        end
      end
      frs_pkg::frs_st_wait: begin
        if (other_fault_shutdown) begin
          state_nxt = frs_pkg::frs_st_latch;
        end else if (!output_cmd_on) begin
          state_nxt = frs_pkg::frs_st_idle;
        end else if (attempt_go) begin
          state_nxt = frs_pkg::frs_st_run;
        end else if (!retries_avail) begin
          state_nxt = frs_pkg::frs_st_latch;
        end
      end
      frs_pkg::frs_st_latch: begin
        // off stays off whatever the command; only a clear releases it
        if (fault_clear && !other_fault_shutdown) begin
          state_nxt = output_cmd_on ? frs_pkg::frs_st_run :
                                      frs_pkg::frs_st_idle;
        end
      end
    endcase
  end

  // reload beats a decrement in the same cycle
  assign attempts_left_nxt =
    reload_cnt ? retry_setting :
    (attempt_go && !continuous) ? attempts_left_r - `FRS_ATTEMPT_STEP :
    attempts_left_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r         <= frs_pkg::frs_st_idle;
      attempts_left_r <= `FRS_ATTEMPTS_RST;
      output_enable_r <= 1'b0;
      retry_wait_r    <= 1'b0;
      latched_off_r   <= 1'b0;
      attempt_start_r <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      attempts_left_r <= attempts_left_nxt;
      output_enable_r <= state_nxt == frs_pkg::frs_st_run;
      retry_wait_r    <= state_nxt == frs_pkg::frs_st_wait;
      latched_off_r   <= state_nxt == frs_pkg::frs_st_latch;
      attempt_start_r <= attempt_go;
    end
  end

  assign output_enable = output_enable_r;
  assign retry_wait    = retry_wait_r;
  assign latched_off   = latched_off_r;
  assign attempt_start = attempt_start_r;
  assign attempts_left = attempts_left_r;

  ////////////////////////////////////////////////////////////////////////////
  // restart spacing timer

  frs_delay_timer u_timer (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .start      (timer_start),
    .delay_code (delay_code),
    .unit_tick  (unit_tick),
    .expired    (timer_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_latch_quiet;
    @(posedge ref_clk) disable iff (srst)
    (latched_off && !fault_clear) |=> (!output_enable && !attempt_start);
  endproperty
  a_latch_quiet: assert property (p_latch_quiet)
    else $error("output restarted while latched off");

  property p_count_down;
    @(posedge ref_clk) disable iff (srst)
    (attempt_go && !continuous && !reload_cnt) |=>
      (attempts_left_r == $past(attempts_left_r) - `FRS_ATTEMPT_STEP && attempt_start);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("attempt did not use one credit");

  property p_continuous;
    @(posedge ref_clk) disable iff (srst)
    (in_wait && timer_expired && output_cmd_on && !other_fault_shutdown && continuous)
      |=> (output_enable && attempt_start);
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous retry did not restart");

  property p_exhausted;
    @(posedge ref_clk) disable iff (srst)
    (in_run && fault_shutdown && output_cmd_on && !retries_avail) |=>
      (latched_off && !output_enable) ##1 (latched_off || $past(fault_clear));
  endproperty
  a_exhausted: assert property (p_exhausted)
    else $error("no latch after attempts used up");

  property p_rearm;
    @(posedge ref_clk) disable iff (srst)
    attempt_start |-> !timer_expired;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("spacing timer not running after attempt start");

  property p_wait_timer;
    @(posedge ref_clk) disable iff (srst)
    (in_wait && !timer_expired) |=> (!attempt_start && !output_enable);
  endproperty
  a_wait_timer: assert property (p_wait_timer)
    else $error("restart before delay elapsed");

  property p_six;
    @(posedge ref_clk) disable iff (srst)
    (fault_clear && retry_setting == `FRS_RETRY_SIX) |=> attempts_left_r == `FRS_RETRY_SIX;
  endproperty
  a_six: assert property (p_six)
    else $error("code six not loaded as six attempts");

  property p_cmd_off;
    @(posedge ref_clk) disable iff (srst)
    (!output_cmd_on && !latched_off && !other_fault_shutdown) |=>
      (!output_enable && !retry_wait && !latched_off);
  endproperty
  a_cmd_off: assert property (p_cmd_off)
    else $error("retrying continued after command off");

  property p_other_fault;
    @(posedge ref_clk) disable iff (srst)
    (other_fault_shutdown && !in_idle) |=> (latched_off && !retry_wait);
  endproperty
  a_other_fault: assert property (p_other_fault)
    else $error("other fault did not stop retrying");

  property p_fresh_on;
    @(posedge ref_clk) disable iff (srst)
    fresh_on |=> (output_enable && attempts_left_r == $past(retry_setting));
  endproperty
  a_fresh_on: assert property (p_fresh_on)
    else $error("fresh turn-on did not reload attempts");

  c_retry_run: cover property (@(posedge ref_clk) disable iff (srst)
    attempt_start ##[1:200] fault_shutdown);
  c_latch: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(latched_off) && attempts_left_r == `FRS_RETRY_NONE);
  c_clear: cover property (@(posedge ref_clk) disable iff (srst)
    latched_off && fault_clear ##1 output_enable);
  c_cont: cover property (@(posedge ref_clk) disable iff (srst)
    attempt_start && continuous);

endmodule

// [hdl/frs_params.svh]
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// field widths
`define FRS_RETRY_W            3
`define FRS_DELAY_W            3
`define FRS_UNITS_W            8

// retry setting codes
`define FRS_RETRY_NONE         3'h0
`define FRS_RETRY_SIX          3'h6
`define FRS_RETRY_CONT         3'h7

// counts and reset values
`define FRS_ATTEMPT_STEP       3'h1
`define FRS_ATTEMPTS_RST       3'h0
`define FRS_UNITS_RST          8'h00
`define FRS_UNIT_ONE           8'h01
`define FRS_UNIT_STEP          8'h01

`endif

// [hdl/frs_pkg.sv]
`include "frs_params.svh"

package frs_pkg;

  typedef logic [`FRS_RETRY_W-1:0] frs_retry_t;
  typedef logic [`FRS_DELAY_W-1:0] frs_delay_t;
  typedef logic [`FRS_UNITS_W-1:0] frs_units_t;

  // gray order along idle -> run -> wait -> latch
  typedef enum logic [1:0] {
    frs_st_idle  = 2'h0,
    frs_st_run   = 2'h1,
    frs_st_wait  = 2'h3,
    frs_st_latch = 2'h2
  } frs_state_e;

  // delay code n means 2**n time units
  function automatic frs_units_t frs_delay_units(input frs_delay_t code);
    frs_units_t u;
    u = `FRS_UNIT_ONE << code;
    return u;
  endfunction

  function automatic logic frs_is_continuous(input frs_retry_t setting);
    return setting == `FRS_RETRY_CONT;
  endfunction

endpackage

// [hdl/frs_delay_timer.sv]
`timescale 1ns/1ps
`include "frs_params.svh"

module frs_delay_timer (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                start,
  input  wire frs_pkg::frs_delay_t delay_code,
  input  wire logic                unit_tick,
  output wire logic                expired
);

  frs_pkg::frs_units_t remaining_r;
  frs_pkg::frs_units_t remaining_nxt;
  wire logic           busy;

  assign busy    = remaining_r != `FRS_UNITS_RST;
  assign expired = !busy;

  // a start in a tick cycle reloads; the tick is not counted against it
  assign remaining_nxt = start ? frs_pkg::frs_delay_units(delay_code) :
                         (busy && unit_tick) ? remaining_r - `FRS_UNIT_STEP :
                         remaining_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      remaining_r <= `FRS_UNITS_RST;
    end else begin
      remaining_r <= remaining_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: independent count of ticks since start

  frs_pkg::frs_units_t seen_r;
  frs_pkg::frs_units_t target_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seen_r   <= `FRS_UNITS_RST;
      target_r <= `FRS_UNITS_RST;
    end else if (start) begin
      seen_r   <= `FRS_UNITS_RST;
      target_r <= frs_pkg::frs_delay_units(delay_code);
    end else if (busy && unit_tick) begin
      seen_r   <= seen_r + `FRS_UNIT_STEP;
    end
  end

  property p_units_exact;
    @(posedge ref_clk) disable iff (srst)
    (busy && !start && unit_tick && remaining_r == `FRS_UNIT_ONE) |=>
      (expired && seen_r == target_r);
  endproperty
  a_units_exact: assert property (p_units_exact)
    else $error("delay expired after wrong number of units");

  property p_start_arms;
    @(posedge ref_clk) disable iff (srst)
    start |=> (!expired && remaining_r == $past(frs_pkg::frs_delay_units(delay_code)));
  endproperty
  a_start_arms: assert property (p_start_arms)
    else $error("delay timer not armed with decoded units");

  c_full_delay: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(expired) && target_r == 8'h80);

endmodule

// [testbench/frs_tick_model.sv]
`timescale 1ns/1ps

// far-side unit generator: one tick every four cycles
// fixed period lets the bench place faults away from tick edges
module frs_tick_model (
  input  wire logic ref_clk,
  input  wire logic srst,
  output wire logic unit_tick
);
  logic [1:0] phase_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign unit_tick = (phase_r == 2'h3);
endmodule

// [testbench/frs_sequencer_test.sv]
`timescale 1ns/1ps

module frs_sequencer_test;
  logic                ref_clk = 1'b0;
  logic                srst    = 1'b1;
  frs_pkg::frs_retry_t retry_setting = 3'h0;
  frs_pkg::frs_delay_t delay_code    = 3'h0;
  logic                cmd_on  = 1'b0;
  logic                fault   = 1'b0;
  logic                other   = 1'b0;
  logic                clr     = 1'b0;
  wire logic           unit_tick;
  wire logic           output_enable;
  wire logic           retry_wait;
  wire logic           latched_off;
  wire logic           attempt_start;
  wire frs_pkg::frs_retry_t attempts_left;
  int                  err_total = 0;
  int                  checks    = 0;
  int                  starts    = 0;
  int                  ticks     = 0;
  int                  k;
  int                  r;

  always #20 ref_clk = ~ref_clk;

  frs_tick_model partner (.ref_clk(ref_clk), .srst(srst), .unit_tick(unit_tick));

  frs_sequencer dut (
    .ref_clk              (ref_clk),
    .srst                 (srst),
    .retry_setting        (retry_setting),
    .delay_code           (delay_code),
    .unit_tick            (unit_tick),
    .output_cmd_on        (cmd_on),
    .fault_shutdown       (fault),
    .other_fault_shutdown (other),
    .fault_clear          (clr),
    .output_enable        (output_enable),
    .retry_wait           (retry_wait),
    .latched_off          (latched_off),
    .attempt_start        (attempt_start),
    .attempts_left        (attempts_left)
  );

  // counted on the rising edge so bench reads at the falling edge never race
  always @(posedge ref_clk) begin
    if (attempt_start === 1'b1) starts = starts + 1;
    if (unit_tick === 1'b1) ticks = ticks + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // trailing idle cycle keeps two pulses on one signal apart
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask

  // returns just after a tick edge, so the next fault misses the tick
  task automatic wait_ticks(input int n);
    ticks = 0;
    while (ticks < n) step(1);
  endtask

  function automatic logic [7:0] units(input logic [2:0] d);
    return 8'h01 << d;
  endfunction

  task automatic episode(input logic [2:0] s, input logic [2:0] d, input int n,
                         input logic off);
    int   i;
    logic early;
    cmd_on = 1'b0;
    step(2);
    retry_setting = s;
    delay_code = d;
    cmd_on = 1'b1;
    step(2);
    cmp(8'(output_enable), 8'h01);
    cmp(8'(attempts_left), 8'(s));
    starts = 0;
    for (i = 0; i <= n; i++) begin
      // odd faults, for delay codes above zero, land one unit into a running spacing window
      early = (i % 2 == 1) && (d != 3'h0);
      wait_ticks(early ? 1 : int'(units(d)) + 1);
      pulse(fault);
      ticks = 0;
      if (i < n) begin
        cmp(8'({output_enable, retry_wait}), 8'h01);
        while (starts <= i && ticks <= 200) step(1);
        cmp(8'(ticks), early ? units(d) - 8'h01 : units(d));
        cmp(8'(attempts_left), (s == 3'h7) ? 8'h07 : 8'(s) - 8'(i) - 8'h01);
      end
    end
    if (off) begin
      cmd_on = 1'b0;
      step(2);
      cmp(8'({output_enable, retry_wait, latched_off}), 8'h00);
    end else begin
      if (s == 3'h7) pulse(other);
      step(1);
      cmp(8'({output_enable, latched_off}), 8'h01);
    end
    wait_ticks(int'(units(d)) + 2);
    cmp(8'(starts), 8'(n));
    if (!off) begin
      pulse(clr);
      step(1);
      cmp(8'({output_enable, latched_off}), 8'h02);
      cmp(8'(attempts_left), 8'(s));
    end
    $display("test done setting %0d delay %0d", s, d);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // about four times the longest expected run
    #2000000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    r = $urandom(350);
    step(2);
    srst = 1'b0;
    for (k = 0; k < 8; k++) begin
      episode(3'(k), 3'($urandom_range(4, 0)), (k == 7) ? 9 : k, 1'b0);
    end
    episode(3'h1, 3'h7, 1, 1'b0);
    episode(3'h7, 3'($urandom_range(3, 0)), 3, 1'b1);
    repeat (4) begin
      r = $urandom_range(6, 1);
      episode(3'(r), 3'($urandom_range(5, 0)), r, 1'b0);
    end
    tally_and_finish;
  end
endmodule
